//--- inc/ccr_pkg.sv
// Package: constants and the core request carrier type of the converter control block
package ccr_pkg;
  localparam logic [7:0] OFF_SC1      = 8'h00;
  localparam logic [7:0] OFF_SC2      = 8'h04;
  localparam logic [7:0] OFF_RH       = 8'h08;
  localparam logic [7:0] OFF_RL       = 8'h0C;
  localparam logic [7:0] OFF_CVH      = 8'h10;
  localparam logic [7:0] OFF_CVL      = 8'h14;
  localparam logic [7:0] OFF_CFG      = 8'h18;
  localparam int         SC1_CONVERSION_COMPLETE_FLAG     = 7;
  localparam int         SC1_AIEN     = 6;
  localparam int         SC1_CONT     = 5;
  localparam int         SC2_ACT      = 7;
  localparam int         SC2_TRIG     = 6;
  localparam int         SC2_CMPEN    = 5;
  localparam int         SC2_CMPGE    = 4;
  localparam int         CFG_LP       = 7;
  localparam int         CFG_DIV_LO   = 5;
  localparam int         CFG_LSMP     = 4;
  localparam int         CFG_MODE_LO  = 2;
  localparam int         CFG_ICLK_LO  = 0;
  localparam logic [4:0] CH_DISABLED  = 5'h1F;
  localparam logic [7:0] SC1_RESET    = 8'h1F;
  localparam logic [7:0] CFG_RESET    = 8'h00;
  localparam logic [1:0] MODE_8BIT    = 2'h0;
  localparam logic [1:0] MODE_10BIT   = 2'h2;
  localparam logic [1:0] ICLK_BUS     = 2'h0;
  localparam logic [1:0] ICLK_BUS_HALF = 2'h1;
  localparam logic [1:0] ICLK_ALT     = 2'h2;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  localparam int         ASYNC_DIV    = 5;

  typedef struct packed {
    logic       start;
    logic       abort;
    logic [4:0] channel;
    logic       long_sample;
    logic       low_power;
    logic       ten_bit;
    logic       clk_en;
  } ccr_core_req_t;
endpackage

//--- core/ccr_clkgen.sv
// Converter clock enable: source select and power-of-two divider
`timescale 1ns/1ps
`default_nettype none
module ccr_clkgen #(
  parameter int ASYNC_DIV = ccr_pkg::ASYNC_DIV
) (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [1:0] src_sel,
  input  wire logic [1:0] div_sel,
  input  wire logic       alt_edge,
  output logic            clk_en
);
  logic       half_reg;
  logic [7:0] async_cnt_reg;
  logic       async_tick;
  logic       src_en;
  logic [2:0] div_cnt_reg;
  logic [2:0] ratio_m1;

  // Internal asynchronous clock is modelled as a free-running tick
  assign async_tick = (async_cnt_reg == 8'(ASYNC_DIV - 1));
  assign ratio_m1   = 3'((4'h1 << div_sel) - 4'h1);

  always_comb
  begin
    case (src_sel)
      ccr_pkg::ICLK_BUS:      src_en = 1'b1;
      ccr_pkg::ICLK_BUS_HALF: src_en = half_reg;
      ccr_pkg::ICLK_ALT:      src_en = alt_edge;
      default:                src_en = async_tick;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      half_reg      <= 1'b0;
      async_cnt_reg <= 8'h00;
    end
    else
    begin
      half_reg      <= ~half_reg;
      async_cnt_reg <= async_tick ? 8'h00 : async_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      div_cnt_reg <= 3'h0;
      clk_en      <= 1'b0;
    end
    else
    begin
      clk_en <= 1'b0;
      if (src_en)
      begin
        if (div_cnt_reg >= ratio_m1)
        begin
          div_cnt_reg <= 3'h0;
          clk_en      <= 1'b1;
        end
        else
        begin
          div_cnt_reg <= div_cnt_reg + 3'h1;
        end
      end
    end
  end
endmodule // ccr_clkgen
`default_nettype wire

//--- core/ccr_compare.sv
// Automatic compare of a conversion result against the compare value
`timescale 1ns/1ps
`default_nettype none
module ccr_compare (
  input  wire logic [9:0] result,
  input  wire logic [1:0] cv_high,
  input  wire logic [7:0] cv_low,
  input  wire logic       ten_bit,
  input  wire logic       ge_sel,
  output logic            met
);
  logic [9:0] res_v;
  logic [9:0] cmp_v;

  // High compare bits only count in the 10-bit width
  assign res_v = ten_bit ? result : {2'b00, result[7:0]};
  assign cmp_v = ten_bit ? {cv_high, cv_low} : {2'b00, cv_low};
  assign met   = ge_sel ? (res_v >= cmp_v) : (res_v < cmp_v);
endmodule // ccr_compare
`default_nettype wire

//--- core/ccr_top.sv
// Converter control, compare and result registers behind an AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
module ccr_top #(
  parameter int ADDR_W    = 8,
  parameter int ASYNC_DIV = ccr_pkg::ASYNC_DIV
) (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              hardware_trigger_input,
  input  wire logic              alternate_clock_input,
  output ccr_pkg::ccr_core_req_t core_req,
  input  wire logic              conv_done,
  input  wire logic [9:0]        conv_result
);
  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] sc1_reg;
  logic       conversion_complete_flag_reg;
  logic       active_reg;
  logic [2:0] sc2_ctl_reg;
  logic [7:0] rh_reg;
  logic [7:0] rl_reg;
  logic [1:0] cvh_reg;
  logic [7:0] cvl_reg;
  logic [7:0] cfg_reg;
  logic       lock_reg;
  logic       start_reg;
  logic       abort_reg;

  function automatic logic is_off(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    is_off = (32'(a) == 32'(off));
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = is_off(a, ccr_pkg::OFF_SC1) || is_off(a, ccr_pkg::OFF_SC2) ||
             is_off(a, ccr_pkg::OFF_RH)  || is_off(a, ccr_pkg::OFF_RL)  ||
             is_off(a, ccr_pkg::OFF_CVH) || is_off(a, ccr_pkg::OFF_CVL) ||
             is_off(a, ccr_pkg::OFF_CFG);
  endfunction

  logic       trig_hw;
  logic       cmp_en;
  logic       cmp_ge;
  logic       ten_bit;
  logic       cont;
  logic [4:0] chan;

  assign trig_hw = sc2_ctl_reg[2];
  assign cmp_en  = sc2_ctl_reg[1];
  assign cmp_ge  = sc2_ctl_reg[0];
  assign ten_bit = (cfg_reg[ccr_pkg::CFG_MODE_LO +: 2] == ccr_pkg::MODE_10BIT);
  assign cont    = sc1_reg[ccr_pkg::SC1_CONT];
  assign chan    = sc1_reg[4:0];

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data accepted in either order
  logic              aw_got_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic              w_got_reg;
  logic [7:0]        wdata_reg;
  logic              wstrb0_reg;
  logic              aw_have;
  logic              w_have;
  logic [ADDR_W-1:0] cur_waddr;
  logic [7:0]        cur_wdata;
  logic              cur_wstrb0;
  logic              wr_fire;
  logic              wr_en;

  assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got_reg & ~s_axi_bvalid;
  assign aw_have    = aw_got_reg | (s_axi_awvalid & s_axi_awready);
  assign w_have     = w_got_reg | (s_axi_wvalid & s_axi_wready);
  assign cur_waddr  = aw_got_reg ? awaddr_reg : s_axi_awaddr;
  assign cur_wdata  = w_got_reg ? wdata_reg : s_axi_wdata[7:0];
  assign cur_wstrb0 = w_got_reg ? wstrb0_reg : s_axi_wstrb[0];
  assign wr_fire    = aw_have & w_have & ~s_axi_bvalid;
  // Registers are one byte wide, so only lane 0 carries a write
  assign wr_en      = wr_fire & cur_wstrb0;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      aw_got_reg   <= 1'b0;
      awaddr_reg   <= '0;
      w_got_reg    <= 1'b0;
      wdata_reg    <= 8'h00;
      wstrb0_reg   <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ccr_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready & ~wr_fire)
      begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready & ~wr_fire)
      begin
        w_got_reg  <= 1'b1;
        wdata_reg  <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(cur_waddr) ? ccr_pkg::RESP_OKAY : ccr_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel with read side effects
  logic rd_fire;
  logic rd_rh;
  logic rd_rl;

  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign rd_rh   = rd_fire & is_off(s_axi_araddr, ccr_pkg::OFF_RH);
  assign rd_rl   = rd_fire & is_off(s_axi_araddr, ccr_pkg::OFF_RL);

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= ccr_pkg::RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(s_axi_araddr) ? ccr_pkg::RESP_OKAY : ccr_pkg::RESP_SLVERR;
      s_axi_rdata  <= 32'h0000_0000;
      if (is_off(s_axi_araddr, ccr_pkg::OFF_SC1))
        s_axi_rdata[7:0] <= {conversion_complete_flag_reg, sc1_reg[6:0]};
      if (is_off(s_axi_araddr, ccr_pkg::OFF_SC2))
        s_axi_rdata[7:0] <= {active_reg, sc2_ctl_reg, 4'h0};
      if (rd_rh)
        s_axi_rdata[7:0] <= ten_bit ? rh_reg : 8'h00;
      if (rd_rl)
        s_axi_rdata[7:0] <= rl_reg;
      if (is_off(s_axi_araddr, ccr_pkg::OFF_CVH))
        s_axi_rdata[7:0] <= {6'h00, cvh_reg};
      if (is_off(s_axi_araddr, ccr_pkg::OFF_CVL))
        s_axi_rdata[7:0] <= cvl_reg;
      if (is_off(s_axi_araddr, ccr_pkg::OFF_CFG))
        s_axi_rdata[7:0] <= cfg_reg;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  logic [2:0] trig_sync_reg;
  logic [2:0] alt_sync_reg;
  logic       hw_edge;
  logic       alt_edge;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      trig_sync_reg <= 3'h0;
      alt_sync_reg  <= 3'h0;
    end
    else
    begin
      trig_sync_reg <= {trig_sync_reg[1:0], hardware_trigger_input};
      alt_sync_reg  <= {alt_sync_reg[1:0], alternate_clock_input};
    end
  end

  assign hw_edge  = trig_sync_reg[1] & ~trig_sync_reg[2];
  assign alt_edge = alt_sync_reg[1] & ~alt_sync_reg[2];

  ////////////////////////////////////////////////////////////////////////
  // Conversion sequencing
  logic sc1_wr;
  logic done_ev;
  logic met;
  logic accept;
  logic load_res;
  logic start_now;
  logic abort_now;

  assign sc1_wr    = wr_en & is_off(cur_waddr, ccr_pkg::OFF_SC1);
  // A completion racing a control-one write belongs to the aborted conversion
  assign done_ev   = conv_done & active_reg & ~sc1_wr;
  assign abort_now = sc1_wr & active_reg;
  assign accept    = done_ev & (~cmp_en | met);
  assign load_res  = accept & ~(lock_reg & ten_bit);
  assign start_now = (sc1_wr & (cur_wdata[4:0] != ccr_pkg::CH_DISABLED) & ~trig_hw) |
                     (hw_edge & trig_hw & ~active_reg & ~sc1_wr &
                      (chan != ccr_pkg::CH_DISABLED)) |
                     (done_ev & cont & (chan != ccr_pkg::CH_DISABLED));

  ccr_compare ccr_compare_inst (
    .result  (conv_result),
    .cv_high (cvh_reg),
    .cv_low  (cvl_reg),
    .ten_bit (ten_bit),
    .ge_sel  (cmp_ge),
    .met     (met)
  );

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      active_reg <= 1'b0;
      start_reg  <= 1'b0;
      abort_reg  <= 1'b0;
    end
    else
    begin
      start_reg <= start_now;
      abort_reg <= abort_now;
      if (start_now)
        active_reg <= 1'b1;
      else if (abort_now | done_ev)
        active_reg <= 1'b0;
    end
  end

  // Set wins over clear so a completion is never lost
  always_ff @(posedge mclk)
  begin
    if (reset)
      conversion_complete_flag_reg <= 1'b0;
    else if (accept)
      conversion_complete_flag_reg <= 1'b1;
    else if (sc1_wr | rd_rl)
      conversion_complete_flag_reg <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      rh_reg <= 8'h00;
      rl_reg <= 8'h00;
    end
    else if (load_res)
    begin
      rh_reg <= ten_bit ? {6'h00, conv_result[9:8]} : 8'h00;
      rl_reg <= conv_result[7:0];
    end
  end

  // High read in 10-bit mode freezes the pair until the low half is read
  always_ff @(posedge mclk)
  begin
    if (reset)
      lock_reg <= 1'b0;
    else if (rd_rl)
      lock_reg <= 1'b0;
    else if (rd_rh & ten_bit)
      lock_reg <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Software-written registers
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      sc1_reg     <= ccr_pkg::SC1_RESET;
      sc2_ctl_reg <= 3'h0;
      cvh_reg     <= 2'h0;
      cvl_reg     <= 8'h00;
      cfg_reg     <= ccr_pkg::CFG_RESET;
    end
    else if (wr_en)
    begin
      if (sc1_wr)
        sc1_reg <= {1'b0, cur_wdata[6:0]};
      // Active flag is read-only and low bits are reserved, so both drop
      if (is_off(cur_waddr, ccr_pkg::OFF_SC2))
        sc2_ctl_reg <= cur_wdata[ccr_pkg::SC2_CMPGE +: 3];
      if (is_off(cur_waddr, ccr_pkg::OFF_CVH))
        cvh_reg <= cur_wdata[1:0];
      if (is_off(cur_waddr, ccr_pkg::OFF_CVL))
        cvl_reg <= cur_wdata;
      if (is_off(cur_waddr, ccr_pkg::OFF_CFG))
        cfg_reg <= cur_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Converter clock and core request
  logic conv_clk_en;

  ccr_clkgen #(
    .ASYNC_DIV (ASYNC_DIV)
  ) ccr_clkgen_inst (
    .mclk     (mclk),
    .reset    (reset),
    .src_sel  (cfg_reg[ccr_pkg::CFG_ICLK_LO +: 2]),
    .div_sel  (cfg_reg[ccr_pkg::CFG_DIV_LO +: 2]),
    .alt_edge (alt_edge),
    .clk_en   (conv_clk_en)
  );

  always_comb
  begin
    core_req.start       = start_reg;
    core_req.abort       = abort_reg;
    core_req.channel     = chan;
    core_req.long_sample = cfg_reg[ccr_pkg::CFG_LSMP];
    core_req.low_power   = cfg_reg[ccr_pkg::CFG_LP];
    core_req.ten_bit     = ten_bit;
    core_req.clk_en      = conv_clk_en;
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_start_active;
    start_now |=> active_reg && start_reg;
  endproperty
  a_start_active: assert property (p_start_active) else $error("start did not set active");

  property p_done_idle;
    done_ev && !start_now |=> !active_reg && !core_req.start;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("active not cleared at end");

  property p_hw_start;
    hw_edge && trig_hw && !active_reg && !sc1_wr && chan != ccr_pkg::CH_DISABLED |=> core_req.start;
  endproperty
  a_hw_start: assert property (p_hw_start) else $error("hardware trigger ignored");

  property p_conversion_complete_flag_clear;
    (sc1_wr || rd_rl) && !accept |=> !conversion_complete_flag_reg;
  endproperty
  a_conversion_complete_flag_clear: assert property (p_conversion_complete_flag_clear) else $error("complete flag not cleared");

  property p_cmp_fail;
    done_ev && cmp_en && !met |=> $stable(rl_reg) && $stable(rh_reg);
  endproperty
  a_cmp_fail: assert property (p_cmp_fail) else $error("result loaded on failed compare");

  property p_load;
    load_res |=> rl_reg == $past(conv_result[7:0]) && conversion_complete_flag_reg;
  endproperty
  a_load: assert property (p_load) else $error("result or flag not updated");

  property p_lock;
    rd_rh && ten_bit ##1 (!rd_rl)[*2] |-> $stable(rl_reg);
  endproperty
  a_lock: assert property (p_lock) else $error("locked result changed");

  property p_rh_zero;
    rd_rh && !ten_bit |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000;
  endproperty
  a_rh_zero: assert property (p_rh_zero) else $error("high result not zero in 8-bit");

  property p_abort;
    sc1_wr && active_reg |=> core_req.abort;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not issued");
endmodule // ccr_top
`default_nettype wire

//--- verification/ccr_core_model.sv
// Behavioural analog core: answers each start that is not aborted after a set delay
`timescale 1ns/1ps
`default_nettype none
module ccr_core_model (
  input  wire logic                   mclk,
  input  wire logic                   reset,
  input  wire ccr_pkg::ccr_core_req_t core_req,
  input  wire logic [7:0]             delay,
  input  wire logic [9:0]             value,
  output logic                        conv_done,
  output logic [9:0]                  conv_result
);
  logic [7:0] cnt_reg;
  logic       busy_reg;

  always_ff @(posedge mclk)
  begin
    // Result lines carry junk outside the done pulse, so a late sample shows up
    conv_done   <= 1'h0;
    conv_result <= ~conv_result;
    if (reset)
    begin
      busy_reg    <= 1'h0;
      conv_result <= 10'h000;
    end
    else if (core_req.start)
    begin
      busy_reg <= 1'h1;
      cnt_reg  <= delay;
    end
    else if (core_req.abort)
      busy_reg <= 1'h0;
    else if (busy_reg && cnt_reg == 8'h00)
    begin
      busy_reg    <= 1'h0;
      conv_done   <= 1'h1;
      conv_result <= value;
    end
    else
      cnt_reg <= cnt_reg - 8'h01;
  end
endmodule // ccr_core_model
`default_nettype wire

//--- verification/ccr_top_tb.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
module ccr_top_tb;
  logic                   mclk, reset, hwt, done;
  logic [7:0]             awaddr, araddr, delay, d, exp_rl, exp_rh;
  logic [31:0]            wdata, rdata, seed;
  logic                   awvalid, awready, wvalid, wready, bvalid, bready;
  logic                   arvalid, arready, rvalid, rready;
  logic                   ten, cmp, ge, hit, vld, lmode;
  logic [1:0]             bresp, rresp, r;
  logic [3:0]             alt_cnt;
  logic [9:0]             value, result, cv;
  ccr_pkg::ccr_core_req_t req;
  int                     fails, checks, i, n, e;

  ccr_top #(.ASYNC_DIV(2)) ccr_top_inst (
    .mclk(mclk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .hardware_trigger_input(hwt), .alternate_clock_input(alt_cnt[1]),
    .core_req(req), .conv_done(done), .conv_result(result));

  ccr_core_model ccr_core_model_inst (
    .mclk(mclk), .reset(reset), .core_req(req), .delay(delay), .value(value),
    .conv_done(done), .conv_result(result));

  initial
  begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  // Alternate source: one rising edge every four cycles
  always @(posedge mclk) alt_cnt <= alt_cnt + 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic met(input logic [9:0] a, input logic [9:0] b, input logic t,
                               input logic g);
    if (!t)
    begin
      a[9:8] = 2'h0;
      b[9:8] = 2'h0;
    end
    return g ? (a >= b) : (a < b);
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic b;
    awaddr  <= a;
    wdata   <= {24'h000000, v};
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    b = 1'h0;
    while (!b)
    begin
      @(posedge mclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      b = bvalid;
      r = bresp;
    end
    // Ready stays high between transfers so no edge sees it toggled twice
  endtask

  task automatic rd(input logic [7:0] a);
    logic g;
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    g = 1'h0;
    while (!g)
    begin
      @(posedge mclk);
      if (arready) arvalid <= 1'h0;
      g = rvalid;
      d = rdata[7:0];
      r = rresp;
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk(d, exp);
  endtask

  // Bounded wait: a lost completion must not hang the run
  task automatic wt;
    n = 0;
    while (!done && n < 400)
    begin
      @(posedge mclk);
      n++;
    end
    chk({7'h00, done}, 8'h01);
    repeat (2) @(posedge mclk);
  endtask

  task automatic conv(input logic [9:0] v);
    value <= v;
    delay <= 8'h0C;
    wr(ccr_pkg::OFF_SC1, 8'h00);
    wt();
  endtask

  task automatic conclude;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {reset, awvalid, wvalid, bready, arvalid, rready, hwt, vld, lmode} = 9'h100;
    {awaddr, araddr, wdata, value, alt_cnt} = 62'h0;
    {fails, checks} = 64'h0;
    delay = 8'h0C;
    seed = 32'hF6F180B4;
    repeat (16) @(posedge mclk);
    reset <= 1'h0;
    @(posedge mclk);
    for (i = 0; i < 7; i++) rc(8'(4 * i), i == 0 ? 8'h1F : 8'h00);
    rd(8'h1C);
    chk({6'h00, r}, {6'h00, ccr_pkg::RESP_SLVERR});
    wr(8'h1C, 8'h00);
    chk({6'h00, r}, {6'h00, ccr_pkg::RESP_SLVERR});
    chk({3'h0, req.channel}, {3'h0, ccr_pkg::CH_DISABLED});
    seed = lfsr(seed);
    wr(ccr_pkg::OFF_CFG, seed[7:0]);
    rc(ccr_pkg::OFF_CFG, seed[7:0]);
    chk({5'h00, req.low_power, req.long_sample, req.ten_bit},
        {5'h00, seed[7], seed[4], seed[3:2] == 2'h2});
    $display("register test done");

    for (i = 0; i < 16; i++)
    begin
      wr(ccr_pkg::OFF_CFG, {1'h0, i[1:0], 3'h0, i[3:2]});
      delay <= 8'hFF;
      wr(ccr_pkg::OFF_SC1, 8'h00);
      n = 0;
      repeat (64)
      begin
        @(posedge mclk);
        n += req.clk_en;
      end
      // Alternate pin edges come every four cycles, the internal tick every two
      e = 64 >> ((i[3:2] == 2'h3 ? 1 : int'(i[3:2])) + int'(i[1:0]));
      chk({7'h00, n >= e - 1 && n <= e + 1}, 8'h01);
      wr(ccr_pkg::OFF_SC1, 8'h1F);
    end
    $display("clock test done");

    for (i = 0; i < 16; i++)
    begin
      seed = lfsr(seed);
      {ge, cmp, ten} = i[2:0];
      cv = i[3] ? seed[9:0] : seed[25:16];
      wr(ccr_pkg::OFF_CFG, {4'h0, ten, 3'h0});
      if (ten != lmode) vld = 1'h0;
      wr(ccr_pkg::OFF_CVH, {6'h00, cv[9:8]});
      wr(ccr_pkg::OFF_CVL, cv[7:0]);
      wr(ccr_pkg::OFF_SC2, {2'h0, cmp, ge, 4'h0});
      conv(seed[9:0]);
      hit = !cmp || met(seed[9:0], cv, ten, ge);
      if (hit)
      begin
        {vld, lmode, exp_rh, exp_rl} = {1'h1, ten, 6'h00, seed[9:0]};
      end
      rd(ccr_pkg::OFF_SC1);
      chk({7'h00, d[7]}, {7'h00, hit});
      rd(ccr_pkg::OFF_RH);
      if (vld || !ten) chk(d, ten ? exp_rh : 8'h00);
      rd(ccr_pkg::OFF_RL);
      if (vld) chk(d, exp_rl);
      rc(ccr_pkg::OFF_SC1, 8'h00);
    end
    $display("compare test done");

    wr(ccr_pkg::OFF_CFG, 8'h08);
    wr(ccr_pkg::OFF_SC2, 8'h00);
    conv(10'h2A5);
    rc(ccr_pkg::OFF_RH, 8'h02);
    conv(10'h15A);
    rc(ccr_pkg::OFF_RL, 8'hA5);
    conv(10'h15A);
    rc(ccr_pkg::OFF_RH, 8'h01);
    rc(ccr_pkg::OFF_RL, 8'h5A);
    wr(ccr_pkg::OFF_CFG, 8'h00);
    conv(10'h0C3);
    rc(ccr_pkg::OFF_RH, 8'h00);
    conv(10'h03C);
    rc(ccr_pkg::OFF_RL, 8'h3C);
    $display("interlock test done");

    wr(ccr_pkg::OFF_SC2, 8'h40);
    delay <= 8'h28;
    wr(ccr_pkg::OFF_SC1, 8'h00);
    rc(ccr_pkg::OFF_SC2, 8'h40);
    hwt <= 1'h1;
    repeat (6) @(posedge mclk);
    hwt <= 1'h0;
    rc(ccr_pkg::OFF_SC2, 8'hC0);
    wt();
    rc(ccr_pkg::OFF_SC2, 8'h40);
    rc(ccr_pkg::OFF_SC1, 8'h80);
    wr(ccr_pkg::OFF_SC2, 8'h00);
    delay <= 8'h64;
    wr(ccr_pkg::OFF_SC1, 8'h00);
    rc(ccr_pkg::OFF_SC1, 8'h00);
    wr(ccr_pkg::OFF_SC1, 8'h00);
    rc(ccr_pkg::OFF_SC2, 8'h80);
    wr(ccr_pkg::OFF_SC1, 8'h1F);
    rc(ccr_pkg::OFF_SC2, 8'h00);
    wr(ccr_pkg::OFF_SC1, 8'h20);
    wt();
    wt();
    wr(ccr_pkg::OFF_SC1, 8'h1F);
    rc(ccr_pkg::OFF_SC2, 8'h00);
    $display("trigger test done");
    conclude();
  end

  initial
  begin
    #500000;
    fails++;
    conclude();
  end
endmodule // ccr_top_tb
`default_nettype wire
